// *** verilog/aesu_defines.svh ***
/*
 * Constants of the accelerometer event and status unit: register
 * offsets, field positions, reset values and state codes.
 * Assumes it is included by bare name wherever these are needed.
 */
`ifndef AESU_DEFINES_SVH
`define AESU_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AESU_ADDR_TRIG_SEL    8'h0a
`define AESU_ADDR_SYS_STATE   8'h0b
`define AESU_ADDR_EVT_SRC     8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AESU_SYS_GERR_BIT     7
`define AESU_SYS_GT_LSB       2
`define AESU_TRIG_LSB         2
`define AESU_EVT_SLEEP_WAKE   7
`define AESU_EVT_BUFFER       6
`define AESU_EVT_TRANSIENT    5
`define AESU_EVT_ORIENT       4
`define AESU_EVT_TAP          3
`define AESU_EVT_FFMT         2
`define AESU_EVT_UNUSED       1
`define AESU_EVT_NEW_SAMPLE   0

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define AESU_RST_BYTE         8'h00
`define AESU_RST_TRIG         4'h0
`define AESU_RST_GT           5'h00
`define AESU_GT_MAX           5'h1f
`define AESU_IDLE_MAX         8'hff
`define AESU_OP_STANDBY       2'h0
`define AESU_OP_WAKE          2'h1
`define AESU_OP_SLEEP         2'h2

`endif

// *** verilog/aesu_pkg.sv ***
/*
 * Types of the accelerometer event and status unit.
 * Assumes nothing of its surroundings.
 */
package aesu_pkg;

	// ------------------------------------------------------------
	// Operating state, one-hot
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		AESU_ST_STANDBY = 3'b001,
		AESU_ST_WAKE    = 3'b010,
		AESU_ST_SLEEP   = 3'b100
	} aesu_mode_t;

	// ------------------------------------------------------------
	// State of the top module apart from the reset release flip-flops
	// ------------------------------------------------------------
	typedef struct packed {
		aesu_mode_t  mode;
		logic [1:0]  op_code;
		logic [3:0]  trig_sel;
		logic [3:0]  trig_latch;
		logic        fifo_trigger;
		logic [7:0]  evt;
		logic [5:0]  prev;
		logic        gate_err;
		logic [4:0]  gate_time;
		logic [7:0]  idle_cnt;
		logic [7:0]  rdata;
		logic        low_rate;
	} aesu_state_t;

	// ------------------------------------------------------------
	// State of the rate divider
	// ------------------------------------------------------------
	typedef struct packed {
		logic [23:0] cnt;
		logic        tick;
	} aesu_div_t;

endpackage

// *** verilog/aesu_odr_divider.sv ***
/*
 * Output-data-rate divider: one-cycle tick every period cycles.
 * Assumes an asynchronous active-low reset and a period of at least 1.
 */
`timescale 1ns/1ns
`default_nettype none

module aesu_odr_divider (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Period in core clock cycles
	input  wire logic [23:0] period,
	// Rate tick
	output logic             tick
);

	aesu_pkg::aesu_div_t s;
	aesu_pkg::aesu_div_t next_s;

	// Count up, wrap and pulse at the end of each period
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt + 24'h000001 >= period) begin
			next_s.cnt = 24'h000000;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 24'h000001;
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

endmodule // aesu_odr_divider

`default_nettype wire

// *** verilog/accel_event_status_unit.sv ***
/*
 * Event collection and status registers of a three-axis accelerometer:
 * FIFO trigger selection, system state with gate error age, and the
 * latched event source byte.
 * Assumes detectors, FIFO and the serial register port run on core_clk
 * and hand over levels and one-cycle read pulses on that clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "aesu_defines.svh"

module accel_event_status_unit (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// Register port
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rdata,
	// Detector flags and interrupt enables
	input  wire logic        transient_active,
	input  wire logic        orientation_changed,
	input  wire logic        tap_active,
	input  wire logic        ffmt_active,
	input  wire logic [5:0]  int_enable,
	// Source register read pulses
	input  wire logic        transient_src_read,
	input  wire logic        orientation_src_read,
	input  wire logic        tap_src_read,
	input  wire logic        ffmt_src_read,
	input  wire logic        buffer_status_read,
	input  wire logic        xyz_read_done,
	// FIFO status
	input  wire logic        fifo_overflow,
	input  wire logic [5:0]  sample_count,
	input  wire logic [5:0]  watermark_level,
	input  wire logic        gate_error_detect,
	// Data ready flags
	input  wire logic        sample_ready_flag,
	input  wire logic        overrun_flag,
	// Mode control
	input  wire logic        active_mode,
	input  wire logic        auto_sleep_en,
	input  wire logic [3:0]  wake_select,
	input  wire logic [7:0]  inactivity_limit,
	input  wire logic [23:0] wake_period,
	input  wire logic [23:0] sleep_period,
	// Status outputs
	output logic [7:0]       event_flags,
	output logic [1:0]       operating_state,
	output logic             fifo_trigger,
	output logic             low_rate
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Register port hit on a given offset
	function automatic logic addr_hit(input logic strobe, input logic [7:0] a,
		input logic [7:0] target);
		addr_hit = strobe && (a == target);
	endfunction

	// Two-bit code of an operating state
	function automatic logic [1:0] state_code(input aesu_pkg::aesu_mode_t m);
		unique case (m)
			aesu_pkg::AESU_ST_WAKE:  state_code = `AESU_OP_WAKE;
			aesu_pkg::AESU_ST_SLEEP: state_code = `AESU_OP_SLEEP;
			default:                 state_code = `AESU_OP_STANDBY;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta;
	logic rst_n;
	// Two flip-flops release the reset on the clock
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ------------------------------------------------------------
	// Rate divider
	// ------------------------------------------------------------
	aesu_pkg::aesu_state_t s;
	aesu_pkg::aesu_state_t next_s;
	logic                  odr_tick;

	// The sleep rate is used only while asleep
	aesu_odr_divider u_div (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.period   (s.low_rate ? sleep_period : wake_period),
		.tick     (odr_tick)
	);

	// ------------------------------------------------------------
	// Event conditions and their rising edges
	// ------------------------------------------------------------
	logic [5:0] cond;
	logic [5:0] rise;
	logic [3:0] src_read;
	logic       wm_match;

	// Watermark of zero disables the match
	assign wm_match = (watermark_level != 6'h00) && (sample_count == watermark_level);

	// Index 0..3 detectors, 4 buffer, 5 new sample; each gated by enable
	always_comb begin
		cond[0] = transient_active && int_enable[0];
		cond[1] = orientation_changed && int_enable[1];
		cond[2] = tap_active && int_enable[2];
		cond[3] = ffmt_active && int_enable[3];
		cond[4] = (fifo_overflow || wm_match) && int_enable[4];
		cond[5] = (sample_ready_flag || overrun_flag) && int_enable[5];
	end
	// Low to high change since the last cycle; read pulses in select-bit order
	assign rise = cond & ~s.prev;
	assign src_read = {transient_src_read, orientation_src_read, tap_src_read, ffmt_src_read};

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic [7:0] evt_set;
	logic [7:0] evt_clr;
	logic       sys_read;
	logic       idle_over;

	assign sys_read = addr_hit(reg_rd, reg_addr, `AESU_ADDR_SYS_STATE);
	assign idle_over = odr_tick && (s.idle_cnt >= inactivity_limit);
	always_comb begin
		next_s = s;
		evt_set = 8'h00;
		evt_clr = 8'h00;
		next_s.prev = cond;

		// Select bits written by software
		if (addr_hit(reg_wr, reg_addr, `AESU_ADDR_TRIG_SEL)) begin
			next_s.trig_sel = reg_wdata[`AESU_TRIG_LSB+3:`AESU_TRIG_LSB];
		end

		// Trigger latches: select bit 5 is transient down to bit 2 freefall/motion
		next_s.trig_latch = (s.trig_latch & ~src_read)
			| ({rise[0], rise[1], rise[2], rise[3]} & s.trig_sel);
		next_s.fifo_trigger = |next_s.trig_latch;

		// Operating state and automatic sleep/wake
		unique case (s.mode)
			aesu_pkg::AESU_ST_STANDBY: begin
				if (active_mode) begin
					next_s.mode = aesu_pkg::AESU_ST_WAKE;
				end
			end
			aesu_pkg::AESU_ST_WAKE: begin
				if (!active_mode) begin
					next_s.mode = aesu_pkg::AESU_ST_STANDBY;
				end else if (auto_sleep_en && idle_over && (rise == 6'h00)) begin
					next_s.mode = aesu_pkg::AESU_ST_SLEEP;
					evt_set[`AESU_EVT_SLEEP_WAKE] = 1'b1;
				end
			end
			aesu_pkg::AESU_ST_SLEEP: begin
				if (!active_mode) begin
					next_s.mode = aesu_pkg::AESU_ST_STANDBY;
				end else if (!auto_sleep_en || ((rise[3:0] & wake_select) != 4'h0)) begin
					next_s.mode = aesu_pkg::AESU_ST_WAKE;
					evt_set[`AESU_EVT_SLEEP_WAKE] = auto_sleep_en;
				end
			end
			default: begin
				next_s.mode = aesu_pkg::AESU_ST_STANDBY;
			end
		endcase
		next_s.op_code = state_code(next_s.mode);
		next_s.low_rate = (next_s.mode == aesu_pkg::AESU_ST_SLEEP);

		// Inactivity count in rate periods, restarted by any event
		if ((rise != 6'h00) || (next_s.mode != aesu_pkg::AESU_ST_WAKE)
			|| (s.mode != aesu_pkg::AESU_ST_WAKE)) begin
			next_s.idle_cnt = 8'h00;
		end else if (odr_tick && (s.idle_cnt != `AESU_IDLE_MAX)) begin
			next_s.idle_cnt = s.idle_cnt + 8'h01;
		end

		// Gate error: sticky until the FIFO is empty, set wins
		if (gate_error_detect) begin
			next_s.gate_err = 1'b1;
		end else if (sample_count == 6'h00) begin
			next_s.gate_err = 1'b0;
		end

		// Gate error age, saturating, zero while no error
		if (!next_s.gate_err || !s.gate_err) begin
			next_s.gate_time = `AESU_RST_GT;
		end else if (odr_tick && (s.gate_time != `AESU_GT_MAX)) begin
			next_s.gate_time = s.gate_time + 5'h01;
		end

		// Event source bits: set on rise, cleared by their own reads
		evt_set[`AESU_EVT_BUFFER]     = rise[4];
		evt_set[`AESU_EVT_TRANSIENT]  = rise[0];
		evt_set[`AESU_EVT_ORIENT]     = rise[1];
		evt_set[`AESU_EVT_TAP]        = rise[2];
		evt_set[`AESU_EVT_FFMT]       = rise[3];
		evt_set[`AESU_EVT_NEW_SAMPLE] = rise[5];
		evt_clr[`AESU_EVT_SLEEP_WAKE] = sys_read;
		evt_clr[`AESU_EVT_BUFFER]     = buffer_status_read;
		evt_clr[`AESU_EVT_TRANSIENT]  = transient_src_read;
		evt_clr[`AESU_EVT_ORIENT]     = orientation_src_read;
		evt_clr[`AESU_EVT_TAP]        = tap_src_read;
		evt_clr[`AESU_EVT_FFMT]       = ffmt_src_read;
		evt_clr[`AESU_EVT_NEW_SAMPLE] = xyz_read_done;
		next_s.evt = (s.evt & ~evt_clr) | evt_set;
		next_s.evt[`AESU_EVT_UNUSED] = 1'b0;

		// Read data, registered one cycle after the strobe
		if (reg_rd) begin
			unique case (reg_addr)
				`AESU_ADDR_TRIG_SEL:
					next_s.rdata = {2'h0, s.trig_sel, 2'h0};
				`AESU_ADDR_SYS_STATE:
					next_s.rdata = {s.gate_err, s.gate_time, s.op_code};
				`AESU_ADDR_EVT_SRC:
					next_s.rdata = s.evt;
				default:
					next_s.rdata = `AESU_RST_BYTE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.mode <= aesu_pkg::AESU_ST_STANDBY;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign reg_rdata = s.rdata;
	assign event_flags = s.evt;
	assign operating_state = s.op_code;
	assign fifo_trigger = s.fifo_trigger;
	assign low_rate = s.low_rate;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_trig_write;
		addr_hit(reg_wr, reg_addr, `AESU_ADDR_TRIG_SEL) |=> s.trig_sel == $past(reg_wdata[5:2]);
	endproperty
	a_trig_write: assert property (p_trig_write) else $error("select bits not written");
	property p_trig_gated;
		(rise[0] && !s.trig_sel[3] && !s.trig_latch[3]) |=> !s.trig_latch[3];
	endproperty
	a_trig_gated: assert property (p_trig_gated) else $error("unselected trigger latched");
	property p_state_code;
		s.op_code == state_code(s.mode);
	endproperty
	a_state_code: assert property (p_state_code) else $error("state code mismatch");
	property p_gerr_hold;
		(s.gate_err && sample_count != 6'h00) |=> s.gate_err;
	endproperty
	a_gerr_hold: assert property (p_gerr_hold) else $error("gate error dropped early");
	property p_gt_zero;
		!s.gate_err |-> s.gate_time == 5'h00;
	endproperty
	a_gt_zero: assert property (p_gt_zero) else $error("gate age not zero");
	property p_evt_hold;
		(s.evt[`AESU_EVT_TRANSIENT] && !transient_src_read) |=> s.evt[`AESU_EVT_TRANSIENT];
	endproperty
	a_evt_hold: assert property (p_evt_hold) else $error("transient event lost");
	property p_sleep_flag;
		$rose(s.low_rate) |-> s.evt[`AESU_EVT_SLEEP_WAKE];
	endproperty
	a_sleep_flag: assert property (p_sleep_flag) else $error("sleep without event");
	property p_wake;
		(s.mode == aesu_pkg::AESU_ST_SLEEP && active_mode && (rise[3:0] & wake_select) != 4'h0)
			|=> s.mode == aesu_pkg::AESU_ST_WAKE;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on selected event");
	property p_drdy_set;
		rise[5] |=> s.evt[`AESU_EVT_NEW_SAMPLE];
	endproperty
	a_drdy_set: assert property (p_drdy_set) else $error("new sample not flagged");
	property p_drdy_hold;
		(s.evt[`AESU_EVT_NEW_SAMPLE] && !xyz_read_done) |=> s.evt[`AESU_EVT_NEW_SAMPLE];
	endproperty
	a_drdy_hold: assert property (p_drdy_hold) else $error("new sample cleared early");
	property p_bit1;
		!event_flags[`AESU_EVT_UNUSED];
	endproperty
	a_bit1: assert property (p_bit1) else $error("unused bit set");
	property p_latch_clr;
		(ffmt_src_read && !rise[3]) |=> !s.trig_latch[0];
	endproperty
	a_latch_clr: assert property (p_latch_clr) else $error("trigger latch not cleared");
	c_sleep: cover property ($rose(s.low_rate));
	c_wake: cover property ($fell(s.low_rate) && active_mode);
	c_trigger: cover property ($rose(s.fifo_trigger));
	c_gate_err: cover property ($rose(s.gate_err) ##[1:40] s.gate_time == 5'h02);

endmodule // accel_event_status_unit

`default_nettype wire

// *** tb/aesu_host_model.sv ***
/*
 * Host model: issues single-byte register reads and writes.
 * Assumes the block samples its strobes on the rising core_clk edge.
 */
`timescale 1ns/1ns
`default_nettype none

module aesu_host_model (
	// Clock
	input  wire logic  core_clk,
	// Register port
	output logic       reg_rd,
	output logic       reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// Bus quiet at time zero
	initial begin
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'hff;
		reg_wdata = 8'hff;
	end

	// One strobe cycle; released lines show the inverse of the last value
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_rd = !w;
		reg_wr = w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule // aesu_host_model

`default_nettype wire

// *** tb/tb.sv ***
/*
 * Self-checking bench of the accelerometer event and status unit.
 * Assumes the host model drives the register port of the block.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
	// --------------------------------------------------------
	// Signals, design and host
	// --------------------------------------------------------
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        reg_rd, reg_wr, rd_seen = 1'b0;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, event_flags, inactivity_limit, wd;
	logic [3:0]  det, wake_select;
	logic [5:0]  clr, int_enable, sample_count, watermark_level;
	logic        fifo_overflow, gate_error_detect, sample_ready_flag, overrun_flag;
	logic        active_mode, auto_sleep_en, fifo_trigger, low_rate;
	logic [1:0]  operating_state;
	logic [23:0] wake_period, sleep_period;
	logic [15:0] q[$];
	logic [15:0] ent;
	logic [15:0] oq[$];
	logic [15:0] oent;
	int          fails = 0, cmp_count = 0, i, n;

	// Clock of 10 ns
	always #5 core_clk = ~core_clk;

	aesu_host_model host (.core_clk(core_clk), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));

	accel_event_status_unit dut (.core_clk(core_clk), .arst_n(arst_n),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.transient_active(det[0]), .orientation_changed(det[1]),
		.tap_active(det[2]), .ffmt_active(det[3]), .int_enable(int_enable),
		.transient_src_read(clr[0]), .orientation_src_read(clr[1]),
		.tap_src_read(clr[2]), .ffmt_src_read(clr[3]),
		.buffer_status_read(clr[4]), .xyz_read_done(clr[5]),
		.fifo_overflow(fifo_overflow), .sample_count(sample_count),
		.watermark_level(watermark_level), .gate_error_detect(gate_error_detect),
		.sample_ready_flag(sample_ready_flag), .overrun_flag(overrun_flag),
		.active_mode(active_mode), .auto_sleep_en(auto_sleep_en),
		.wake_select(wake_select), .inactivity_limit(inactivity_limit),
		.wake_period(wake_period), .sleep_period(sleep_period),
		.event_flags(event_flags), .operating_state(operating_state),
		.fifo_trigger(fifo_trigger), .low_rate(low_rate));

	// --------------------------------------------------------
	// Checking
	// --------------------------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
		cmp_count++;
		if ((g & m) !== (e & m)) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	// Status output picked by a note's kind code
	function automatic logic [7:0] out_sel(input logic [7:0] k);
		case (k)
			8'h00: out_sel = event_flags;
			8'h01: out_sel = {6'h00, operating_state};
			8'h02: out_sel = {7'h00, fifo_trigger};
			default: out_sel = {7'h00, low_rate};
		endcase
	endfunction

	task automatic chk_out(input logic [7:0] k, input logic [7:0] e);
		logic [7:0] g;
		g = out_sel(k);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t output %0d got %h expected %h", $time, k, g, e);
		end
	endtask

	// Note an expected status output for the watcher
	task automatic ck(input logic [7:0] k, input logic [7:0] e);
		oq.push_back({k, e});
	endtask

	task complete_run;
		if (q.size() > 0 || oq.size() > 0) begin
			fails++;
		end
		if (fails == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Note the expected byte, then let the host read
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		q.push_back({m, e});
		host.xfer(1'b0, a, 8'h00);
	endtask

	task automatic tick(input int k);
		repeat (k) @(negedge core_clk);
	endtask

	task automatic pulse(input logic [5:0] m);
		clr = m;
		tick(1);
		clr = 6'h00;
		tick(1);
	endtask

	// Read data lands one cycle after the strobe edge
	always @(posedge core_clk) rd_seen <= reg_rd;
	always @(negedge core_clk) begin
		if (rd_seen && q.size() > 0) begin
			ent = q.pop_front();
			chk(reg_rdata, ent[7:0], ent[15:8]);
		end
	end

	// Status outputs settle after the rising edge; compare every note
	always @(negedge core_clk) begin
		#1;
		while (oq.size() > 0) begin
			oent = oq.pop_front();
			chk_out(oent[15:8], oent[7:0]);
		end
	end

	// Cut a hang short
	initial begin
		#100000;
		fails++;
		complete_run;
	end

	// --------------------------------------------------------
	// Tests
	// --------------------------------------------------------
	initial begin
		void'($urandom(93542));
		{det, clr, int_enable, sample_count, watermark_level} = '0;
		{fifo_overflow, gate_error_detect, sample_ready_flag, overrun_flag} = 4'h0;
		{active_mode, auto_sleep_en} = 2'b00;
		wake_select = 4'h4;
		inactivity_limit = 8'h02;
		wake_period = 24'h000004;
		sleep_period = 24'h000008;
		tick(8);
		arst_n = 1'b1;
		tick(3);
		// Reset values, unmapped offset, write rules
		rd(8'h0a, 8'h00, 8'hff);
		rd(8'h0b, 8'h00, 8'hff);
		rd(8'h0c, 8'h00, 8'hff);
		rd(8'h0d, 8'h00, 8'hff);
		wd = 8'($urandom);
		host.xfer(1'b1, 8'h0a, wd);
		rd(8'h0a, {2'b00, wd[5:2], 2'b00}, 8'hff);
		host.xfer(1'b1, 8'h0b, 8'hff);
		rd(8'h0b, 8'h00, 8'hff);
		host.xfer(1'b1, 8'h0a, 8'h00);
		// Each detector: masked, set on rise, held, cleared by its read
		for (i = 0; i < 4; i++) begin
			det[i] = 1'b1;
			tick(1);
			ck(8'h00, 8'h00);
			det[i] = 1'b0;
			int_enable[i] = 1'b1;
			tick(1);
			det[i] = 1'b1;
			tick(1);
			ck(8'h00, 8'h20 >> i);
			rd(8'h0c, 8'h20 >> i, 8'hff);
			pulse(6'h01 << i);
			ck(8'h00, 8'h00);
			ck(8'h02, 8'h00);
			det[i] = 1'b0;
			int_enable[i] = 1'b0;
		end
		// Trigger selection by bit position: bit 2 freefall, bit 5 transient
		host.xfer(1'b1, 8'h0a, 8'h04);
		int_enable = 6'h0f;
		det[0] = 1'b1;
		tick(1);
		ck(8'h02, 8'h00);
		det[3] = 1'b1;
		tick(1);
		ck(8'h02, 8'h01);
		pulse(6'h08);
		ck(8'h02, 8'h00);
		ck(8'h00, 8'h20);
		pulse(6'h01);
		det = 4'h0;
		host.xfer(1'b1, 8'h0a, 8'h20);
		det[0] = 1'b1;
		tick(1);
		ck(8'h02, 8'h01);
		pulse(6'h01);
		ck(8'h02, 8'h00);
		det = 4'h0;
		// Buffer watermark and overflow
		wd = 8'(($urandom % 31) + 1);
		watermark_level = wd[5:0];
		int_enable = 6'h10;
		sample_count = wd[5:0] - 6'h01;
		tick(1);
		ck(8'h00, 8'h00);
		sample_count = wd[5:0];
		tick(1);
		ck(8'h00, 8'h40);
		pulse(6'h10);
		ck(8'h00, 8'h00);
		// Overflow needs a fresh rise, so the watermark match ends first
		sample_count = 6'h00;
		tick(1);
		fifo_overflow = 1'b1;
		tick(1);
		ck(8'h00, 8'h40);
		pulse(6'h10);
		fifo_overflow = 1'b0;
		// New sample: only the axis data read clears it
		int_enable = 6'h20;
		sample_ready_flag = 1'b1;
		tick(1);
		ck(8'h00, 8'h01);
		rd(8'h00, 8'h00, 8'hff);
		rd(8'h0c, 8'h01, 8'hff);
		pulse(6'h10);
		ck(8'h00, 8'h01);
		pulse(6'h20);
		ck(8'h00, 8'h00);
		// Overrun alone needs the ready level gone first to make a rise
		sample_ready_flag = 1'b0;
		tick(1);
		overrun_flag = 1'b1;
		tick(1);
		ck(8'h00, 8'h01);
		pulse(6'h20);
		overrun_flag = 1'b0;
		// Wake, gate error and its clearing
		active_mode = 1'b1;
		tick(1);
		ck(8'h01, 8'h01);
		sample_count = 6'h03;
		gate_error_detect = 1'b1;
		tick(1);
		gate_error_detect = 1'b0;
		tick(8);
		rd(8'h0b, 8'h81, 8'h83);
		sample_count = 6'h00;
		tick(2);
		rd(8'h0b, 8'h01, 8'hff);
		// Idle into sleep, selected event back to wake
		int_enable = 6'h04;
		auto_sleep_en = 1'b1;
		for (n = 0; n < 80 && operating_state !== 2'h2; n++) tick(1);
		ck(8'h01, 8'h02);
		ck(8'h03, 8'h01);
		ck(8'h00, 8'h80);
		rd(8'h0b, 8'h02, 8'hff);
		ck(8'h00, 8'h00);
		det[2] = 1'b1;
		tick(1);
		ck(8'h01, 8'h01);
		ck(8'h00, 8'h88);
		// Let the watchers take the last notes before the verdict
		tick(2);
		complete_run;
	end
endmodule // tb

`default_nettype wire
